// ### include/bats_cfg.svh
// Constants of the advertising telegram sequencer
`ifndef BATS_CFG_SVH
`define BATS_CFG_SVH
`define BATS_CLK_MHZ 250
`define BATS_GAP_LONG_MS 20
`define BATS_GAP_SHORT_MS 10
`define BATS_GAP_LONG_CYC (`BATS_GAP_LONG_MS * 1000 * `BATS_CLK_MHZ)
`define BATS_GAP_SHORT_CYC (`BATS_GAP_SHORT_MS * 1000 * `BATS_CLK_MHZ)
`define BATS_PREAMBLE 8'hAA
`define BATS_ACCESS_ADDR 32'h8E89BED6
`define BATS_ADV_TYPE 4'h2
`define BATS_TXADD_RANDOM 1'h1
`define BATS_ADDR_LEN 6'h06
`define BATS_PAYLOAD_MAX 6'h1F
`define BATS_DEV_TYPE 16'h5A3C // Device type code, value arbitrary
`define BATS_CRC_INIT 24'h555555
`define BATS_CRC_POLY 24'h00065B
`define BATS_STD_CHAN_MAX 7'h27
`define BATS_CUSTOM_BASE 7'h28
`define BATS_RPA_TOP 2'h2
`define BATS_LFSR_SEED 22'h2A5C31
`endif

// ### include/bats_pkg.sv
// Types of the advertising telegram sequencer
package bats_pkg;
    typedef enum logic [1:0] {
        BATS_SEQ_DEFAULT,
        BATS_SEQ_THREE,
        BATS_SEQ_TWO,
        BATS_SEQ_ONE
    } bats_seq_e;
    typedef enum logic [2:0] {
        BATS_F_PRE,
        BATS_F_ACC,
        BATS_F_HDR,
        BATS_F_ADR,
        BATS_F_PAY,
        BATS_F_CRC
    } bats_field_e;
    typedef logic [6:0] bats_chan_t;
endpackage

// ### rtl/bats_crc24.sv
// Serial 24-bit frame checksum, one byte per step, LSB first
`timescale 1ns/1ps
`include "bats_cfg.svh"
module bats_crc24 (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic init,
    input wire logic dataValid,
    input wire logic [7:0] dataByte,
    // Result
    output logic [23:0] crc
);
    logic [23:0] crc_ff;
    logic [23:0] nxt_crc;

    // Eight serial LFSR steps over one byte
    always_comb begin
        nxt_crc = crc_ff;
        for (int i = 0; i < 8; i++) begin
            if (nxt_crc[23] ^ dataByte[i]) begin
                nxt_crc = {nxt_crc[22:0], 1'b0} ^ `BATS_CRC_POLY;
            end else begin
                nxt_crc = {nxt_crc[22:0], 1'b0};
            end
        end
    end

    // Register holds running checksum
    always_ff @(posedge core_clk) begin
        if (rst || init) begin
            crc_ff <= `BATS_CRC_INIT;
        end else if (dataValid) begin
            crc_ff <= nxt_crc;
        end
    end

    assign crc = crc_ff;
endmodule

// ### rtl/bats_sequencer.sv
// Advertising telegram sequencer: framing, channel plan, intervals
`timescale 1ns/1ps
`include "bats_cfg.svh"
module bats_sequencer
    import bats_pkg::*;
#(
    parameter int GAP_LONG_CYC = `BATS_GAP_LONG_CYC,
    parameter int GAP_SHORT_CYC = `BATS_GAP_SHORT_CYC,
    parameter int PAY_MAX = 31
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Configuration
    input wire logic [1:0] sequenceSettingA,
    input wire logic shortInterval,
    input wire logic addrPrivacy,
    input wire bats_chan_t firstChannelSelect,
    input wire bats_chan_t secondChannelSelect,
    input wire bats_chan_t thirdChannelSelect,
    input wire logic [31:0] devAddrWrData,
    input wire logic devAddrWrEn,
    output logic [47:0] staticAddr,
    // Private address hash supplied from outside
    input wire logic [23:0] rpaHash,
    // Telegram request
    input wire logic telegramStart,
    input wire logic [5:0] payloadLen,
    input wire logic [8*PAY_MAX-1:0] payloadData,
    output logic busy,
    // Radio byte stream
    output logic txActive,
    output bats_chan_t txChannel,
    output logic [6:0] whitenInit,
    output logic txByteValid,
    output logic [7:0] txByte,
    input wire logic txByteReady,
    output logic txFrameEnd
);
    // Refuse parameter values the frame walker cannot serve
    if (PAY_MAX != 31 || GAP_SHORT_CYC < 1 || GAP_LONG_CYC < 1) begin
        $error("bats_sequencer: unsupported parameters");
    end

    logic [31:0] devLow_ff;
    logic [21:0] lfsr_ff;
    logic [47:0] srcAddr_ff;
    logic [5:0] payLen_ff;
    logic [8*PAY_MAX-1:0] payData_ff;
    logic busy_ff;
    logic sending_ff;
    logic [2:0] event_ff;
    logic [1:0] slot_ff;
    logic [31:0] gap_ff;
    bats_field_e field_ff;
    logic [5:0] idx_ff;
    bats_seq_e plan;
    logic [2:0] events;
    logic [1:0] slots;
    logic [15:0] header;
    logic [7:0] curByte;
    logic fieldLast;
    logic byteGo;
    logic frameDone;
    logic lastSlot;
    logic lastEvent;
    logic [23:0] crcVal;
    logic crcInit;
    logic crcFeed;
    bats_chan_t chanSel;

    // Per-device address part, rewritable over configuration port
    always_ff @(posedge core_clk) begin
        if (rst) begin
            devLow_ff <= 32'h00000000;
        end else if (devAddrWrEn) begin
            devLow_ff <= devAddrWrData;
        end
    end
    assign staticAddr = {`BATS_DEV_TYPE, devLow_ff};

    // Random part of private address, stepped per telegram
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lfsr_ff <= `BATS_LFSR_SEED;
        end else if (telegramStart && !busy_ff) begin
            lfsr_ff <= {lfsr_ff[20:0], lfsr_ff[21] ^ lfsr_ff[20]};
        end
    end

    // Latch address and payload once per telegram
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srcAddr_ff <= 48'h000000000000;
            payLen_ff <= 6'h00;
            payData_ff <= '0;
        end else if (telegramStart && !busy_ff) begin
            if (addrPrivacy) begin
                srcAddr_ff <= {`BATS_RPA_TOP, lfsr_ff, rpaHash};
            end else begin
                srcAddr_ff <= staticAddr;
            end
            payLen_ff <= (payloadLen > `BATS_PAYLOAD_MAX) ?
                `BATS_PAYLOAD_MAX : payloadLen;
            payData_ff <= payloadData;
        end
    end

    // Plan from sequence_setting_a setting
    always_comb begin
        plan = bats_seq_e'(sequenceSettingA);
        unique case (plan)
            BATS_SEQ_DEFAULT: begin
                events = 3'd3;
                slots = 2'd2;
            end
            BATS_SEQ_THREE: begin
                events = 3'd3;
                slots = 2'd2;
            end
            BATS_SEQ_TWO: begin
                events = 3'd4;
                slots = 2'd1;
            end
            BATS_SEQ_ONE: begin
                events = 3'd6;
                slots = 2'd0;
            end
        endcase
    end

    // Channel of current slot; default plan uses advertising channels
    always_comb begin
        if (plan == BATS_SEQ_DEFAULT) begin
            chanSel = 7'(37 + slot_ff);
        end else begin
            unique case (slot_ff)
                2'd0: chanSel = firstChannelSelect;
                2'd1: chanSel = secondChannelSelect;
                default: chanSel = thirdChannelSelect;
            endcase
        end
    end
    assign txChannel = chanSel;
    // Whitening seed: channel index or MHz offset for custom channels
    always_comb begin
        if (chanSel <= `BATS_STD_CHAN_MAX) begin
            whitenInit = chanSel;
        end else begin
            whitenInit = 7'((chanSel - `BATS_CUSTOM_BASE) * 2 + 3);
        end
    end

    // Header bits from top: 00, length, rx 0, tx random, 00, type
    assign header = {2'b00, 6'(`BATS_ADDR_LEN + payLen_ff), 1'b0,
        `BATS_TXADD_RANDOM, 2'b00, `BATS_ADV_TYPE};

    // Current frame byte, LSB byte first within each field
    always_comb begin
        curByte = 8'h00;
        fieldLast = 1'b0;
        unique case (field_ff)
            BATS_F_PRE: begin
                curByte = `BATS_PREAMBLE;
                fieldLast = 1'b1;
            end
            BATS_F_ACC: begin
                curByte = 8'(`BATS_ACCESS_ADDR >> (8 * idx_ff));
                fieldLast = (idx_ff == 6'd3);
            end
            BATS_F_HDR: begin
                curByte = 8'(header >> (8 * idx_ff));
                fieldLast = (idx_ff == 6'd1);
            end
            BATS_F_ADR: begin
                curByte = 8'(srcAddr_ff >> (8 * idx_ff));
                fieldLast = (idx_ff == 6'd5);
            end
            BATS_F_PAY: begin
                curByte = 8'(payData_ff >> (8 * idx_ff));
                fieldLast = (idx_ff == payLen_ff - 6'd1);
            end
            BATS_F_CRC: begin
                curByte = 8'(crcVal >> (8 * idx_ff));
                fieldLast = (idx_ff == 6'd2);
            end
        endcase
    end

    assign byteGo = sending_ff && txByteReady;
    assign frameDone = byteGo && field_ff == BATS_F_CRC && fieldLast;
    assign lastSlot = (slot_ff == slots);
    assign lastEvent = (event_ff == events - 3'd1);

    // Field walker through one frame
    always_ff @(posedge core_clk) begin
        if (rst) begin
            field_ff <= BATS_F_PRE;
            idx_ff <= 6'h00;
        end else if (byteGo) begin
            if (!fieldLast) begin
                idx_ff <= idx_ff + 6'd1;
            end else begin
                idx_ff <= 6'h00;
                unique case (field_ff)
                    BATS_F_PRE: field_ff <= BATS_F_ACC;
                    BATS_F_ACC: field_ff <= BATS_F_HDR;
                    BATS_F_HDR: field_ff <= BATS_F_ADR;
                    BATS_F_ADR: field_ff <= (payLen_ff == 6'h00) ?
                        BATS_F_CRC : BATS_F_PAY;
                    BATS_F_PAY: field_ff <= BATS_F_CRC;
                    BATS_F_CRC: field_ff <= BATS_F_PRE;
                endcase
            end
        end
    end

    // Slot, event and interval sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            sending_ff <= 1'b0;
            slot_ff <= 2'd0;
            event_ff <= 3'd0;
            gap_ff <= 32'd0;
        end else if (!busy_ff) begin
            if (telegramStart) begin
                busy_ff <= 1'b1;
                sending_ff <= 1'b1;
                slot_ff <= 2'd0;
                event_ff <= 3'd0;
            end
        end else if (sending_ff) begin
            if (frameDone) begin
                if (!lastSlot) begin
                    slot_ff <= slot_ff + 2'd1;
                end else if (lastEvent) begin
                    sending_ff <= 1'b0;
                    busy_ff <= 1'b0;
                end else begin
                    sending_ff <= 1'b0;
                    gap_ff <= shortInterval ? GAP_SHORT_CYC - 1 :
                        GAP_LONG_CYC - 1;
                end
            end
        end else if (gap_ff != 32'd0) begin
            gap_ff <= gap_ff - 32'd1;
        end else begin
            sending_ff <= 1'b1;
            slot_ff <= 2'd0;
            event_ff <= event_ff + 3'd1;
        end
    end

    // Checksum over header, address and payload
    assign crcInit = byteGo && field_ff == BATS_F_ACC;
    assign crcFeed = byteGo && (field_ff == BATS_F_HDR ||
        field_ff == BATS_F_ADR || field_ff == BATS_F_PAY);

    bats_crc24 u_crc (
        .core_clk(core_clk),
        .rst(rst),
        .init(crcInit),
        .dataValid(crcFeed),
        .dataByte(curByte),
        .crc(crcVal)
    );

    assign busy = busy_ff;
    assign txActive = sending_ff;
    assign txByteValid = sending_ff;
    assign txByte = curByte;
    assign txFrameEnd = frameDone;

    // Checks
    sequence s_slotEnd;
        frameDone && !lastSlot;
    endsequence
    property p_slotStep;
        @(posedge core_clk) disable iff (rst)
        s_slotEnd |=> sending_ff && slot_ff == $past(slot_ff) + 2'd1;
    endproperty
    a_slotStep: assert property (p_slotStep)
        else $error("slot did not advance back to back");

    property p_preamble;
        @(posedge core_clk) disable iff (rst)
        sending_ff && field_ff == BATS_F_PRE |-> txByte == 8'hAA;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("wrong preamble");

    property p_access;
        @(posedge core_clk) disable iff (rst)
        sending_ff && field_ff == BATS_F_ACC && idx_ff == 6'd0
            |-> txByte == 8'hD6;
    endproperty
    a_access: assert property (p_access)
        else $error("wrong access address byte");

    property p_hdrType;
        @(posedge core_clk) disable iff (rst)
        sending_ff && field_ff == BATS_F_HDR && idx_ff == 6'd0
            |-> txByte == 8'h42;
    endproperty
    a_hdrType: assert property (p_hdrType)
        else $error("wrong header low byte");

    property p_devType;
        @(posedge core_clk) disable iff (rst)
        $past(devAddrWrEn)
            |-> staticAddr == {`BATS_DEV_TYPE, $past(devAddrWrData)};
    endproperty
    a_devType: assert property (p_devType)
        else $error("device type bytes altered");

    property p_gapLoad;
        @(posedge core_clk) disable iff (rst)
        frameDone && lastSlot && !lastEvent && shortInterval
            |=> !sending_ff && gap_ff == GAP_SHORT_CYC - 1;
    endproperty
    a_gapLoad: assert property (p_gapLoad)
        else $error("short interval not loaded");

    property p_addrHold;
        @(posedge core_clk) disable iff (rst)
        busy_ff && $past(busy_ff) |-> $stable(srcAddr_ff);
    endproperty
    a_addrHold: assert property (p_addrHold)
        else $error("address changed within telegram");

    property p_oneChan;
        @(posedge core_clk) disable iff (rst)
        sending_ff && plan == BATS_SEQ_ONE
            |-> txChannel == firstChannelSelect;
    endproperty
    a_oneChan: assert property (p_oneChan)
        else $error("single-channel plan left first channel");

    property p_rpaTop;
        @(posedge core_clk) disable iff (rst)
        telegramStart && !busy_ff && addrPrivacy
            |=> srcAddr_ff[47:46] == 2'b10;
    endproperty
    a_rpaTop: assert property (p_rpaTop)
        else $error("private address top bits wrong");
endmodule

// ### tb/bats_radio_rx.sv
// Radio receiver model: takes the byte stream with random stalls
`timescale 1ns/1ps
module bats_radio_rx
    import bats_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Radio byte stream
    input wire logic txActive,
    input wire bats_chan_t txChannel,
    input wire logic [6:0] whitenInit,
    input wire logic txByteValid,
    input wire logic [7:0] txByte,
    output logic txByteReady
);
    logic [7:0] rxQ[$];
    int chQ[$];
    int wiQ[$];
    int idleQ[$];
    int idleCnt;
    int pos;
    int flen;

    // Stall pattern, moved at the falling edge
    initial txByteReady = 1'b0;
    always @(negedge core_clk) txByteReady <= ($urandom_range(3) != 0);

    // Collect bytes; frame length comes from the header length field
    always @(posedge core_clk) begin
        if (rst) begin
            idleCnt = 0;
            pos = 0;
            flen = 64;
        end else if (txByteValid && txByteReady) begin
            if (pos == 0) begin
                chQ.push_back(txChannel);
                wiQ.push_back(whitenInit);
                idleQ.push_back(idleCnt);
            end
            if (pos == 6) flen = 10 + txByte[5:0];
            rxQ.push_back(txByte);
            pos = (pos > 6 && pos == flen - 1) ? 0 : pos + 1;
            idleCnt = 0;
        end else if (!txActive) begin
            idleCnt = idleCnt + 1;
        end
    end
endmodule

// ### tb/ble_adv_telegram_sequencer_test.sv
// Self-checking bench for the advertising telegram sequencer
`timescale 1ns/1ps
`include "bats_cfg.svh"
module ble_adv_telegram_sequencer_test
    import bats_pkg::*;
;
    localparam int GAP_L = 20;
    localparam int GAP_S = 10;
    logic core_clk, rst, shortInterval, addrPrivacy, devAddrWrEn;
    logic telegramStart, busy, txActive, txByteValid, txFrameEnd;
    logic txByteReady;
    logic [1:0] sequenceSettingA;
    bats_chan_t firstChannelSelect, secondChannelSelect;
    bats_chan_t thirdChannelSelect, txChannel;
    logic [31:0] devAddrWrData;
    logic [47:0] staticAddr, staticExp;
    logic [23:0] rpaHash, lastPrand;
    logic [5:0] payloadLen;
    logic [8*31-1:0] payloadData;
    logic [6:0] whitenInit;
    logic [7:0] txByte;
    int nErrors = 0;
    int testsRun = 0;
    bit havePrand = 0;
    int nEnds = 0;

    // Count frame-end pulses as the radio accepts the last byte
    always @(posedge core_clk) if (txFrameEnd) nEnds++;

    bats_sequencer #(.GAP_LONG_CYC(GAP_L), .GAP_SHORT_CYC(GAP_S),
        .PAY_MAX(31)) u_bats_sequencer (.core_clk(core_clk), .rst(rst),
        .sequenceSettingA(sequenceSettingA), .shortInterval(shortInterval),
        .addrPrivacy(addrPrivacy), .firstChannelSelect(firstChannelSelect),
        .secondChannelSelect(secondChannelSelect),
        .thirdChannelSelect(thirdChannelSelect),
        .devAddrWrData(devAddrWrData), .devAddrWrEn(devAddrWrEn),
        .staticAddr(staticAddr), .rpaHash(rpaHash),
        .telegramStart(telegramStart), .payloadLen(payloadLen),
        .payloadData(payloadData), .busy(busy), .txActive(txActive),
        .txChannel(txChannel), .whitenInit(whitenInit),
        .txByteValid(txByteValid), .txByte(txByte),
        .txByteReady(txByteReady), .txFrameEnd(txFrameEnd));

    bats_radio_rx u_bats_radio_rx (.core_clk(core_clk), .rst(rst),
        .txActive(txActive), .txChannel(txChannel), .whitenInit(whitenInit),
        .txByteValid(txByteValid), .txByte(txByte),
        .txByteReady(txByteReady));

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        if (nErrors == 0 && testsRun > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(string nm, logic [47:0] exp, logic [47:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Checksum over header, address and payload, LSB bit first
    function automatic logic [23:0] crc_of(logic [7:0] b[$]);
        logic [23:0] c;
        logic fb;
        c = 24'h555555;
        foreach (b[i]) for (int k = 0; k < 8; k++) begin
            fb = c[23] ^ b[i][k];
            c = {c[22:0], 1'b0} ^ (fb ? 24'h00065B : 24'h000000);
        end
        return c;
    endfunction

    function automatic int whiten_of(int ch);
        return ch <= 39 ? ch : 3 + 2 * (ch - 40);
    endfunction

    // Rewrite the per-device low address word
    task automatic wr_addr();
        devAddrWrData = $urandom;
        devAddrWrEn = 1'b1;
        @(negedge core_clk);
        devAddrWrEn = 1'b0;
        staticExp = {`BATS_DEV_TYPE, devAddrWrData};
        @(negedge core_clk);
        chk("staticAddr", staticExp, staticAddr);
    endtask

    // One telegram: drive, then check every slot of the plan
    task automatic run_tel(int md, logic sh, logic pv, int len, bit stray);
        int chs[3];
        int per;
        int nev;
        int w;
        int id;
        int ends0;
        logic [7:0] f[$];
        logic [7:0] e[$];
        logic [7:0] h[$];
        logic [47:0] a;
        logic [23:0] c;
        sequenceSettingA = md[1:0];
        shortInterval = sh;
        addrPrivacy = pv;
        firstChannelSelect = 7'($urandom_range(78));
        secondChannelSelect = 7'($urandom_range(78));
        thirdChannelSelect = 7'($urandom_range(78));
        rpaHash = 24'($urandom);
        payloadLen = 6'(len);
        for (int i = 0; i < 31; i++) payloadData[8*i+:8] = 8'($urandom);
        chs = '{firstChannelSelect, secondChannelSelect, thirdChannelSelect};
        if (md == 0) chs = '{37, 38, 39};
        per = (md == 2) ? 2 : (md == 3) ? 1 : 3;
        nev = (md == 2) ? 4 : (md == 3) ? 6 : 3;
        ends0 = nEnds;
        telegramStart = 1'b1;
        @(negedge core_clk);
        telegramStart = 1'b0;
        for (int ev = 0; ev < nev; ev++) for (int s = 0; s < per; s++) begin
            w = 0;
            while (u_bats_radio_rx.rxQ.size() < 16 + len && w < 3000) begin
                @(negedge core_clk);
                w++;
            end
            if (w == 3000) begin
                chk("frame wait", 1, 0);
                return;
            end
            if (stray && ev == 0 && s == 0) begin
                telegramStart = 1'b1;
                @(negedge core_clk);
                telegramStart = 1'b0;
            end
            f.delete();
            repeat (16 + len) f.push_back(u_bats_radio_rx.rxQ.pop_front());
            chk("channel", chs[s], u_bats_radio_rx.chQ.pop_front());
            chk("whiten", whiten_of(chs[s]), u_bats_radio_rx.wiQ.pop_front());
            id = u_bats_radio_rx.idleQ.pop_front();
            if (s > 0) chk("slot gap", 0, id);
            if (ev > 0 && s == 0) chk("event gap", (sh ? GAP_S : GAP_L), id);
            if (ev == 0 && s == 0) begin
                a = {f[12], f[11], f[10], f[9], f[8], f[7]};
                if (pv) begin
                    chk("prand top", 2'b10, a[47:46]);
                    chk("hash", rpaHash, a[23:0]);
                    if (havePrand) chk("prand new", 1, a[47:24] != lastPrand);
                    lastPrand = a[47:24];
                    havePrand = 1;
                end else begin
                    a = staticExp;
                end
            end
            h = '{8'h42, 8'(6 + len)};
            for (int i = 0; i < 6; i++) h.push_back(a[8*i+:8]);
            for (int i = 0; i < len; i++) h.push_back(payloadData[8*i+:8]);
            c = crc_of(h);
            e = '{8'hAA, 8'hD6, 8'hBE, 8'h89, 8'h8E};
            e = {e, h, c[7:0], c[15:8], c[23:16]};
            foreach (e[i]) chk("frame byte", e[i], f[i]);
        end
        w = 0;
        while (busy !== 1'b0 && w < 200) begin
            @(negedge core_clk);
            w++;
        end
        repeat (40) @(negedge core_clk);
        chk("busy", 0, busy);
        chk("extra bytes", 0, u_bats_radio_rx.rxQ.size());
        chk("frame ends", nev * per, nEnds - ends0);
    endtask

    // Watchdog
    initial begin
        #200000;
        nErrors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        void'($urandom(89370));
        {rst, shortInterval, addrPrivacy, devAddrWrEn, telegramStart} = 5'h10;
        sequenceSettingA = 2'h0;
        firstChannelSelect = 7'h25;
        secondChannelSelect = 7'h26;
        thirdChannelSelect = 7'h27;
        devAddrWrData = 32'h0;
        rpaHash = 24'h0;
        payloadLen = 6'h00;
        payloadData = '0;
        staticExp = {`BATS_DEV_TYPE, 32'h0};
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        chk("staticAddr", staticExp, staticAddr);
        for (int m = 0; m < 4; m++) run_tel(m, m[0], 0, m * 10, 0);
        run_tel(1, 0, 0, 31, 1);
        wr_addr();
        run_tel(2, 1, 1, 3, 0);
        run_tel(3, 0, 1, 31, 0);
        for (int i = 0; i < 6; i++) begin
            wr_addr();
            run_tel($urandom_range(3), 1'($urandom_range(1)),
                1'($urandom_range(1)), $urandom_range(31), 0);
        end
        end_of_test();
    end
endmodule
